/* dma_channel_addr_ctrl.sv */
// Channel 1 current-address registers and low control word of the DMA controller
`timescale 1ns/100ps

// Overview of operation
// - The current destination address is a 32-bit register that is updated after each destination transfer.
// - Each destination transfer increments, decrements or keeps the destination address per its step field.
// - Transfer type codes 000 to 011 select the four transfer types with the DMA as flow controller.
// - Codes 100 and 101 hand flow control to the source peripheral, 110 and 111 to the destination peripheral.
// - The source burst length field at bits 16 to 14 sets the items read per source burst request.
// - Bits 31 to 23 and 19 to 17 of the control word are reserved and have no function.
// - The current source address is a 32-bit register stepped after each source transfer.
module dma_channel_addr_ctrl
  import dma_ch1_pkg::*;
(
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RSTN_IN,
  input  wire logic                CE_IN,
  input  wire logic [ADDR_W-1:0]   REG_ADDR_IN,
  input  wire logic                REG_WR_IN,
  input  wire logic                REG_RD_IN,
  input  wire logic [31:0]         REG_WDATA_IN,
  output logic      [31:0]         REG_RDATA_OUT,
  input  wire logic                SRC_XFER_DONE_IN,
  input  wire logic                DEST_XFER_DONE_IN,
  output logic      [31:0]         SRC_ADDR_OUT,
  output logic      [31:0]         DEST_ADDR_OUT,
  output dma_ch1_pkg::xfer_type_t  XFER_TYPE_OUT,
  output dma_ch1_pkg::flow_ctrl_t  FLOW_CTRL_OUT,
  output logic      [8:0]          SRC_BURST_ITEMS_OUT,
  output logic      [2:0]          SRC_ITEM_WIDTH_OUT,
  output logic      [2:0]          DEST_ITEM_WIDTH_OUT
);
  import dma_ch1_pkg::*;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ==========================================================================
  // Field decode
  // ==========================================================================
  ch_state_t   st_q;
  ch_state_t   st_d;
  logic [2:0]  tt_sel;
  logic [2:0]  sbl_sel;
  logic [1:0]  src_step;
  logic [1:0]  dest_step;
  logic [31:0] src_next;
  logic [31:0] dest_next;

  assign tt_sel    = st_q.ctrl[TT_LSB +: 3];
  assign sbl_sel   = st_q.ctrl[SBL_LSB +: 3];
  assign src_step  = st_q.ctrl[SINC_LSB +: 2];
  assign dest_step = st_q.ctrl[DEST_ADDR_STEP_SELECT_LSB +: 2];

  assign SRC_ITEM_WIDTH_OUT  = st_q.ctrl[SW_LSB +: 3];
  assign DEST_ITEM_WIDTH_OUT = st_q.ctrl[DW_LSB +: 3];
  assign SRC_ADDR_OUT        = st_q.src_addr;
  assign DEST_ADDR_OUT       = st_q.dest_addr;
  assign REG_RDATA_OUT       = st_q.rdata;

  dma_addr_step u_src_step (
    .addr_in       (st_q.src_addr),
    .step_sel_in   (src_step),
    .width_in      (SRC_ITEM_WIDTH_OUT),
    .next_addr_out (src_next)
  );

  dma_addr_step u_dest_step (
    .addr_in       (st_q.dest_addr),
    .step_sel_in   (dest_step),
    .width_in      (DEST_ITEM_WIDTH_OUT),
    .next_addr_out (dest_next)
  );

  // Burst size: 000 is one item, otherwise 4 doubling up to 256
  always_comb
  begin
    if (sbl_sel == 3'h0)
      SRC_BURST_ITEMS_OUT = 9'h001;
    else
      // Widened before the add so code 111 reaches 256 instead of wrapping to one
      SRC_BURST_ITEMS_OUT = 9'h001 << ({1'b0, sbl_sel} + 4'h1);
  end

  always_comb
  begin
    case (tt_sel)
      3'h0:    begin XFER_TYPE_OUT = XFER_MEM_TO_MEM; FLOW_CTRL_OUT = FLOW_BY_DMA;      end
      3'h1:    begin XFER_TYPE_OUT = XFER_MEM_TO_PER; FLOW_CTRL_OUT = FLOW_BY_DMA;      end
      3'h2:    begin XFER_TYPE_OUT = XFER_PER_TO_MEM; FLOW_CTRL_OUT = FLOW_BY_DMA;      end
      3'h3:    begin XFER_TYPE_OUT = XFER_PER_TO_PER; FLOW_CTRL_OUT = FLOW_BY_DMA;      end
      3'h4:    begin XFER_TYPE_OUT = XFER_PER_TO_MEM; FLOW_CTRL_OUT = FLOW_BY_SRC_PER;  end
      3'h5:    begin XFER_TYPE_OUT = XFER_PER_TO_PER; FLOW_CTRL_OUT = FLOW_BY_SRC_PER;  end
      3'h6:    begin XFER_TYPE_OUT = XFER_MEM_TO_PER; FLOW_CTRL_OUT = FLOW_BY_DEST_PER; end
      default: begin XFER_TYPE_OUT = XFER_PER_TO_PER; FLOW_CTRL_OUT = FLOW_BY_DEST_PER; end
    endcase
  end

  // ==========================================================================
  // Register file and address update
  // ==========================================================================
  logic wr_src;
  logic wr_dest;
  logic wr_ctrl;

  assign wr_src  = REG_WR_IN && (REG_ADDR_IN == OFF_SOURCE_ADDR_LOWER);
  assign wr_dest = REG_WR_IN && (REG_ADDR_IN == OFF_DEST_ADDR_LOWER);
  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == OFF_CHANNEL_CTRL_LOW);

  always_comb
  begin
    st_d = st_q;
    // A software write wins over a transfer in the same cycle, so a reload is never stepped
    if (wr_src)
      st_d.src_addr = REG_WDATA_IN;
    else if (SRC_XFER_DONE_IN)
      st_d.src_addr = src_next;
    if (wr_dest)
      st_d.dest_addr = REG_WDATA_IN;
    else if (DEST_XFER_DONE_IN)
      st_d.dest_addr = dest_next;
    if (wr_ctrl)
      st_d.ctrl = (REG_WDATA_IN & CTRL_WR_MASK) | (RST_CTRL_LOW & ~CTRL_WR_MASK);
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        OFF_SOURCE_ADDR_LOWER: st_d.rdata = st_q.src_addr;
        OFF_DEST_ADDR_LOWER:   st_d.rdata = st_q.dest_addr;
        OFF_CHANNEL_CTRL_LOW:  st_d.rdata = st_q.ctrl;
        OFF_SOURCE_ADDR_UPPER: st_d.rdata = UPPER_READ_VALUE;
        OFF_DEST_ADDR_UPPER:   st_d.rdata = UPPER_READ_VALUE;
        default:               st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.src_addr  <= RST_ADDR;
      st_q.dest_addr <= RST_ADDR;
      st_q.ctrl      <= RST_CTRL_LOW;
      st_q.rdata     <= 32'h0000_0000;
    end
    else if (CE_IN)
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!rst_n);

  a_dest_addr_inc: assert property (
    (CE_IN && DEST_XFER_DONE_IN && !wr_dest && dest_step == 2'h0 && DEST_ITEM_WIDTH_OUT == 3'h2)
      |=> (DEST_ADDR_OUT == $past(DEST_ADDR_OUT) + 32'h0000_0004))
    else $error("destination address did not step up by four");

  a_dest_addr_dec: assert property (
    (CE_IN && DEST_XFER_DONE_IN && !wr_dest && dest_step == 2'h1 && DEST_ITEM_WIDTH_OUT == 3'h0)
      |=> (DEST_ADDR_OUT == $past(DEST_ADDR_OUT) - 32'h0000_0001))
    else $error("destination address did not step down by one");

  a_dest_addr_hold: assert property (
    (CE_IN && !DEST_XFER_DONE_IN && !wr_dest) |=> $stable(DEST_ADDR_OUT))
    else $error("destination address moved without a transfer");

  a_dest_fixed_mode: assert property (
    (dest_step[1] && !wr_dest && !wr_ctrl) [*2] |-> $stable(DEST_ADDR_OUT))
    else $error("destination address moved in no-change mode");

  a_src_addr_inc: assert property (
    (CE_IN && SRC_XFER_DONE_IN && !wr_src && src_step == 2'h0 && SRC_ITEM_WIDTH_OUT == 3'h1)
      |=> (SRC_ADDR_OUT == $past(SRC_ADDR_OUT) + 32'h0000_0002))
    else $error("source address did not step up by two");

  a_flow_by_dma: assert property (
    (tt_sel[2] == 1'b0) |-> (FLOW_CTRL_OUT == FLOW_BY_DMA && XFER_TYPE_OUT == tt_sel[1:0]))
    else $error("low transfer codes not flow-controlled by the DMA");

  a_flow_by_periph: assert property (
    (tt_sel == 3'h7) |-> (FLOW_CTRL_OUT == FLOW_BY_DEST_PER && XFER_TYPE_OUT == XFER_PER_TO_PER))
    else $error("code 111 not flow-controlled by destination peripheral");

  a_burst_length: assert property (
    (sbl_sel == 3'h7) |-> (SRC_BURST_ITEMS_OUT == 9'h100))
    else $error("largest source burst is not 256 items");

  a_ctrl_reserved: assert property (
    (CE_IN && wr_ctrl) |=> ((st_q.ctrl & ~CTRL_WR_MASK) == (RST_CTRL_LOW & ~CTRL_WR_MASK)))
    else $error("reserved control bits changed on write");

endmodule : dma_channel_addr_ctrl

/* dma_ch1_pkg.sv */
// Package of register offsets, field layouts and encodings for the channel 1 address slice
package dma_ch1_pkg;

  // ==========================================================================
  // Register offsets (byte addresses relative to the controller base)
  // ==========================================================================
  localparam int unsigned ADDR_W                = 8;
  localparam logic [7:0]  OFF_SOURCE_ADDR_LOWER = 8'h58;
  localparam logic [7:0]  OFF_SOURCE_ADDR_UPPER = 8'h5C;
  localparam logic [7:0]  OFF_DEST_ADDR_LOWER   = 8'h60;
  localparam logic [7:0]  OFF_DEST_ADDR_UPPER   = 8'h64;
  localparam logic [7:0]  OFF_CHANNEL_CTRL_LOW  = 8'h70;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] RST_ADDR              = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL_LOW          = 32'h0206_1201;
  localparam logic [31:0] UPPER_READ_VALUE      = 32'h0000_0000;

  // ==========================================================================
  // Control word field positions
  // ==========================================================================
  localparam int unsigned TT_LSB   = 20;  // transfer_type_flow_select [22:20]
  localparam int unsigned SBL_LSB  = 14;  // source_burst_length [16:14]
  localparam int unsigned SINC_LSB = 9;   // source address step [10:9]
  localparam int unsigned DEST_ADDR_STEP_SELECT_LSB = 7;   // dest_addr_step_select [8:7]
  localparam int unsigned SW_LSB   = 4;   // source_item_width [6:4]
  localparam int unsigned DW_LSB   = 1;   // destination item width [3:1]
  // Writable bits: everything except [31:23] and [19:17]
  localparam logic [31:0] CTRL_WR_MASK = 32'h0071_FFFF;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;

  typedef enum logic [1:0] {
    XFER_MEM_TO_MEM = 2'h0,
    XFER_MEM_TO_PER = 2'h1,
    XFER_PER_TO_MEM = 2'h2,
    XFER_PER_TO_PER = 2'h3
  } xfer_type_t;

  typedef enum logic [1:0] {
    FLOW_BY_DMA      = 2'h0,
    FLOW_BY_SRC_PER  = 2'h1,
    FLOW_BY_DEST_PER = 2'h2
  } flow_ctrl_t;

  typedef struct packed {
    logic [31:0] src_addr;
    logic [31:0] dest_addr;
    logic [31:0] ctrl;
    logic [31:0] rdata;
  } ch_state_t;

endpackage : dma_ch1_pkg

/* dma_addr_step.sv */
// Next-address calculator for one address pointer of a DMA channel
`timescale 1ns/100ps

module dma_addr_step
  import dma_ch1_pkg::*;
(
  input  wire logic [31:0] addr_in,
  input  wire logic [1:0]  step_sel_in,
  input  wire logic [2:0]  width_in,
  output logic      [31:0] next_addr_out
);

  logic [31:0] bytes;

  // Step size equals the item width in bytes; codes above 32 bytes saturate
  always_comb
  begin
    bytes = (width_in > 3'h5) ? 32'h0000_0020 : (32'h0000_0001 << width_in);
    case (step_sel_in)
      STEP_INC: next_addr_out = addr_in + bytes;
      STEP_DEC: next_addr_out = addr_in - bytes;
      default:  next_addr_out = addr_in;
    endcase
  end

endmodule : dma_addr_step

/* dma_xfer_partner.sv */
// Bus-side model of memories and peripherals that report finished item transfers
`timescale 1ns/100ps

module dma_xfer_partner
(
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [3:0] count_in,
  input  wire logic [1:0] gap_in,
  output logic            src_done_out = 1'b0,
  output logic            dest_done_out = 1'b0,
  output logic            busy_out = 1'b0
);
  // ==========================================================================
  // Pulse train
  // A nonzero gap models a slow peripheral; zero gives back-to-back items
  always @(posedge clk_in)
  begin
    if (go_in)
    begin
      busy_out <= 1'b1;
      #1;
      for (int i = 0; i < count_in; i++)
      begin
        src_done_out = 1'b1;
        dest_done_out = 1'b1;
        @(posedge clk_in);
        #1;
        if (gap_in != 2'h0)
        begin
          src_done_out = 1'b0;
          dest_done_out = 1'b0;
          repeat (gap_in) @(posedge clk_in);
          #1;
        end
      end
      src_done_out = 1'b0;
      dest_done_out = 1'b0;
      @(posedge clk_in);
      busy_out <= 1'b0;
    end
  end
endmodule : dma_xfer_partner

/* dma_channel_addr_ctrl_test.sv */
// Self-checking bench for the channel 1 address and control slice
`timescale 1ns/100ps

module dma_channel_addr_ctrl_test;
  import dma_ch1_pkg::*;
  logic        clk, rstn, ce, wr, rd, go, src_done, dest_done, busy;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, src_addr, dest_addr, sa, da, ctl;
  logic [3:0]  count;
  logic [1:0]  gap;
  xfer_type_t  xfer_type;
  flow_ctrl_t  flow_ctrl;
  logic [8:0]  burst;
  logic [2:0]  src_w, dest_w;
  int          failures, n_tests;
  logic [1:0]  type_tbl [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h3};
  logic [1:0]  flow_tbl [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  logic [7:0]  reg_tbl [6] = '{8'h58, 8'h5C, 8'h60, 8'h64, 8'h70, 8'h84};

  dma_channel_addr_ctrl uut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .SRC_XFER_DONE_IN(src_done), .DEST_XFER_DONE_IN(dest_done), .SRC_ADDR_OUT(src_addr),
    .DEST_ADDR_OUT(dest_addr), .XFER_TYPE_OUT(xfer_type), .FLOW_CTRL_OUT(flow_ctrl),
    .SRC_BURST_ITEMS_OUT(burst), .SRC_ITEM_WIDTH_OUT(src_w), .DEST_ITEM_WIDTH_OUT(dest_w));
  dma_xfer_partner partner (.clk_in(clk), .go_in(go), .count_in(count), .gap_in(gap),
    .src_done_out(src_done), .dest_done_out(dest_done), .busy_out(busy));

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One strobe, then an idle cycle so a strobe is never lowered and raised in one step
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = is_wr;
    rd = !is_wr;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    @(posedge clk);
    #1;
  endtask : bus

  // Item width codes above five step by 32 bytes
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] s,
                                       input logic [2:0] w);
    logic [31:0] b;
    b = (w > 3'h5) ? 32'h20 : (32'h1 << w);
    return (s == 2'h0) ? a + b : (s == 2'h1) ? a - b : a;
  endfunction : step

  task automatic tally_and_finish();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    {rstn, wr, rd, go, addr, wdata, count, gap} = '0;
    ce = 1'b1;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'hC826BF17));
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // Writes to upper words and an unmapped place must leave everything at reset
    bus(1'b1, OFF_SOURCE_ADDR_UPPER, 32'hFFFFFFFF);
    bus(1'b1, OFF_DEST_ADDR_UPPER, 32'hFFFFFFFF);
    bus(1'b1, 8'h84, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, reg_tbl[i], 32'h0);
      check(rdata, (i == 4) ? RST_CTRL_LOW : 32'h0);
    end
    for (int i = 0; i < 24; i++)
    begin
      sa = $urandom;
      da = (i == 0) ? 32'h0 : $urandom;
      ctl = $urandom;
      ctl[22:20] = i[2:0];
      ctl[8:7] = (i == 0) ? 2'h1 : (i == 2) ? 2'h0 : ctl[8:7];
      ctl[10:9] = (i == 3) ? 2'h1 : ctl[10:9];
      ctl[6:4] = (i == 3) ? 3'h7 : 3'($urandom_range(5));
      ctl[3:1] = (i == 2) ? 3'h6 : 3'($urandom_range(5));
      count = 4'($urandom_range(6, 1));
      gap = i[0] ? 2'h0 : 2'($urandom_range(3));
      bus(1'b1, OFF_SOURCE_ADDR_LOWER, sa);
      bus(1'b1, OFF_DEST_ADDR_LOWER, da);
      bus(1'b1, OFF_CHANNEL_CTRL_LOW, ctl);
      check({30'h0, xfer_type}, {30'h0, type_tbl[i % 8]});
      check({30'h0, flow_ctrl}, {30'h0, flow_tbl[i % 8]});
      check({23'h0, burst}, 32'h1 << ((ctl[16:14] == 3'h0) ? 0 : ctl[16:14] + 1));
      check({26'h0, src_w, dest_w}, {26'h0, ctl[6:4], ctl[3:1]});
      bus(1'b0, OFF_CHANNEL_CTRL_LOW, 32'h0);
      check(rdata, (ctl & CTRL_WR_MASK) | (RST_CTRL_LOW & ~CTRL_WR_MASK));
      go = 1'b1;
      @(posedge clk);
      #1;
      go = 1'b0;
      for (int k = 0; k < 40 && busy !== 1'b0; k++)
      begin
        @(posedge clk);
        #1;
      end
      check({31'h0, busy}, 32'h0);
      for (int k = 0; k < count; k++)
      begin
        sa = step(sa, ctl[10:9], ctl[6:4]);
        da = step(da, ctl[8:7], ctl[3:1]);
      end
      check(src_addr, sa);
      check(dest_addr, da);
      bus(1'b0, OFF_DEST_ADDR_LOWER, 32'h0);
      check(rdata, da);
    end
    // A write while the clock enable is low must not land
    ce = 1'b0;
    bus(1'b1, OFF_DEST_ADDR_LOWER, ~da);
    ce = 1'b1;
    check(dest_addr, da);
    tally_and_finish();
  end
endmodule : dma_channel_addr_ctrl_test
